// [hw/dclc_params.svh]
// offsets, fields, reset values and timing counts of the code latch control block
`ifndef DCLC_PARAMS_SVH
`define DCLC_PARAMS_SVH

// register byte addresses (one aligned word each)
`define DCLC_ADDR_CMD     12'h000
`define DCLC_ADDR_START   12'h004
`define DCLC_ADDR_STATUS  12'h008
`define DCLC_ADDR_PENDING 12'h00C
`define DCLC_ADDR_LATCH   12'h010
`define DCLC_ADDR_RETURN  12'h014
`define DCLC_ADDR_CONFIG  12'h018
`define DCLC_ADDR_W       12

// command word layout
`define DCLC_CMD_OP_HI    31
`define DCLC_CMD_OP_LO    28
`define DCLC_CMD_DATA_HI  11
`define DCLC_CMD_DATA_LO  0

// command opcodes
`define DCLC_OP_CODE      4'h0
`define DCLC_OP_LOAD      4'h1
`define DCLC_OP_CODE_LOAD 4'h2
`define DCLC_OP_RETURN    4'h3
`define DCLC_OP_CONFIG    4'h4
`define DCLC_OP_REF       4'h5
`define DCLC_OP_POWER     4'h6
`define DCLC_OP_SOFTWARE_CLEAR_CMD  4'h7
`define DCLC_OP_SOFTWARE_RESET_CMD  4'h8
`define DCLC_OP_HOLD      4'h9

// status bits
`define DCLC_ST_AUX_LEVEL 0
`define DCLC_ST_HELD      1
`define DCLC_ST_GATED     2
`define DCLC_ST_ACKED     3
`define DCLC_ST_CAL_BUSY  4
`define DCLC_ST_CLEARING  5

// config readback fields
`define DCLC_CFG_AUX_LO   0
`define DCLC_CFG_REF_LO   2
`define DCLC_CFG_PD_LO    4
`define DCLC_CFG_HOLD     6

// reset values
`define DCLC_RST_CODE     12'h000
`define DCLC_RST_REF      2'h0
`define DCLC_RST_PD       2'h0

// calibration time after power-up
`define DCLC_CAL_TIME_US  200
`define DCLC_CLK_MHZ      100
`define DCLC_CAL_CNT_W    16

`endif

// [hw/dclc_pkg.sv]
// types of the code latch control block
package dclc_pkg;

  // auxiliary input modes; clear mode is the reset default
  typedef enum logic [1:0] {
    DCLC_AUX_CLEAR,
    DCLC_AUX_HOLD,
    DCLC_AUX_OFF
  } dclc_aux_mode_t;

  // reference selection: external, then the three internal values
  typedef enum logic [1:0] {
    DCLC_REF_EXT,
    DCLC_REF_2V048,
    DCLC_REF_2V500,
    DCLC_REF_4V096
  } dclc_ref_t;

  typedef enum logic [1:0] {
    DCLC_BUS_IDLE,
    DCLC_BUS_WAIT,
    DCLC_BUS_RESP
  } dclc_bus_t;

  typedef struct packed {
    logic [1:0] aux_sync;
    logic [1:0] load_sync;
    logic [11:0] pending;
    logic [11:0] latch;
    logic [11:0] retval;
    logic [11:0] out_code;
    dclc_aux_mode_t aux_mode;
    dclc_ref_t ref_sel;
    logic [1:0] pd_mode;
    logic sw_hold;
    logic gated;
    logic acked;
    logic [15:0] cal_cnt;
    dclc_bus_t bus;
    logic wr;
    logic [11:0] addr;
    logic [31:0] rdata;
  } dclc_state_t;

endpackage

// [hw/dclc_core.sv]
// code latch control core with an AHB-Lite register slave
// Notes on behaviour
// - latch width follows 8, 10 or 12 bits
// - power-on reset sets latch to zero code
// - command selects config or code registers
// - code and code-load commands write pending
// - latch from code-load, load command, strobe
// - power-down keeps pending and latch values
// - commands still act during power-down
// - software clear loads both with default
// - software reset restores defaults, zeroes codes
// - reference select: three internal or external
// - reference defaults to external after reset
// - config sets aux clear, hold or off
// - clear mode low forces default codes
// - clear during sequence ignores gated commands
// - gated ignored commands lose their acknowledge
// - reads during clear complete normally
// - gating lifts at start after release
// - status shows aux level and hold
// - hold drives default, restores latch after
// - writes proceed normally while held
// - readback returns stored values while held
// - strobe low copies pending into latch
// - strobe low updates on every code command
// - commands ignored during power-up calibration
//
// Our own choices: the AHB-Lite register port and the register offsets.
`include "dclc_params.svh"

module dclc_core #(
  parameter int RES = 12,
  parameter int CAL_CYCLES = `DCLC_CAL_TIME_US * `DCLC_CLK_MHZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic aux_n,
  input wire logic load_strobe_n,
  output logic [RES-1:0] dac_code,
  output logic [1:0] ref_select,
  output logic [1:0] power_down_mode
);

  initial begin
    if (RES != 8 && RES != 10 && RES != 12) begin
      $error("dclc_core: RES must be 8, 10 or 12");
    end
    if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << `DCLC_CAL_CNT_W)) begin
      $error("dclc_core: CAL_CYCLES out of range");
    end
  end

  localparam logic [11:0] CODE_MASK = 12'(((1 << RES) - 1));
  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

  dclc_pkg::dclc_state_t r;
  dclc_pkg::dclc_state_t next_r;

  // only RES bits of a code are kept; upper bits read as zero
  function automatic logic [11:0] fit_code(input logic [31:0] w);
    fit_code = w[`DCLC_CMD_DATA_HI:`DCLC_CMD_DATA_LO] & CODE_MASK;
  endfunction

  function automatic logic is_gated_op(input logic [3:0] op);
    is_gated_op = (op == `DCLC_OP_CODE) || (op == `DCLC_OP_LOAD) ||
                  (op == `DCLC_OP_CODE_LOAD) || (op == `DCLC_OP_RETURN);
  endfunction

  logic aux_low;
  logic load_low;
  logic clearing;
  logic held;
  logic cal_busy;
  logic addr_take;
  logic do_write;
  logic [3:0] op;
  logic [11:0] cmd_code;
  logic cmd_ok;

  always_comb begin
    next_r = r;
    // second stage is the only reader of the first
    next_r.aux_sync = {r.aux_sync[0], aux_n};
    next_r.load_sync = {r.load_sync[0], load_strobe_n};
    aux_low = ~r.aux_sync[1];
    load_low = ~r.load_sync[1];
    clearing = aux_low && (r.aux_mode == dclc_pkg::DCLC_AUX_CLEAR);
    cal_busy = (r.cal_cnt != CAL_LAST);
    addr_take = hsel && htrans[1] && hready;
    do_write = (r.bus == dclc_pkg::DCLC_BUS_WAIT) && r.wr;
    op = hwdata[`DCLC_CMD_OP_HI:`DCLC_CMD_OP_LO];
    cmd_code = fit_code(hwdata);
    cmd_ok = 1'b0;

    if (cal_busy) begin
      next_r.cal_cnt = r.cal_cnt + 16'h0001;
    end

    // gating is sticky while clear is seen
    if (clearing) begin
      next_r.gated = 1'b1;
    end

    // register writes land in the data phase
    if (do_write && !cal_busy) begin
      if (r.addr == `DCLC_ADDR_START) begin
        // gating lifts only once clear is gone
        if (!clearing) begin
          next_r.gated = 1'b0;
        end
      end else if (r.addr == `DCLC_ADDR_CMD) begin
        cmd_ok = !(is_gated_op(op) && (r.gated || clearing));
        next_r.acked = cmd_ok;
        if (cmd_ok) begin
          case (op)
            `DCLC_OP_CODE: begin
              next_r.pending = cmd_code;
            end
            `DCLC_OP_LOAD: begin
              next_r.latch = r.pending;
            end
            `DCLC_OP_CODE_LOAD: begin
              next_r.pending = cmd_code;
              next_r.latch = cmd_code;
            end
            `DCLC_OP_RETURN: begin
              next_r.retval = cmd_code;
            end
            `DCLC_OP_CONFIG: begin
              if (hwdata[1:0] <= 2'h2) begin
                next_r.aux_mode = dclc_pkg::dclc_aux_mode_t'(hwdata[1:0]);
              end
            end
            `DCLC_OP_REF: begin
              next_r.ref_sel = dclc_pkg::dclc_ref_t'(hwdata[1:0]);
            end
            `DCLC_OP_POWER: begin
              next_r.pd_mode = hwdata[1:0];
            end
            `DCLC_OP_SOFTWARE_CLEAR_CMD: begin
              next_r.pending = r.retval;
              next_r.latch = r.retval;
            end
            `DCLC_OP_SOFTWARE_RESET_CMD: begin
              next_r.pending = `DCLC_RST_CODE;
              next_r.latch = `DCLC_RST_CODE;
              next_r.retval = `DCLC_RST_CODE;
              next_r.aux_mode = dclc_pkg::DCLC_AUX_CLEAR;
              next_r.ref_sel = dclc_pkg::DCLC_REF_EXT;
              next_r.pd_mode = `DCLC_RST_PD;
              next_r.sw_hold = 1'b0;
            end
            `DCLC_OP_HOLD: begin
              next_r.sw_hold = hwdata[0];
            end
            default: begin
              next_r.acked = 1'b0;
            end
          endcase
        end
      end else if (r.addr == `DCLC_ADDR_RETURN) begin
        // direct write of the default value is gated like its command
        if (!(r.gated || clearing)) begin
          next_r.retval = fit_code(hwdata);
        end
      end
    end

    // strobe low copies pending, level sensitive
    // so every code command reaches the latch
    if (load_low) begin
      next_r.latch = next_r.pending;
    end

    // clear forces both codes, beats every write
    if (clearing) begin
      next_r.pending = next_r.retval;
      next_r.latch = next_r.retval;
    end

    // hold shows default without touching latch
    held = r.sw_hold || (aux_low && (next_r.aux_mode == dclc_pkg::DCLC_AUX_HOLD));
    next_r.out_code = held ? next_r.retval : next_r.latch;

    // bus: one wait state so read data comes from a flop
    case (r.bus)
      dclc_pkg::DCLC_BUS_IDLE: begin
        if (addr_take) begin
          next_r.bus = dclc_pkg::DCLC_BUS_WAIT;
          next_r.wr = hwrite;
          next_r.addr = haddr[`DCLC_ADDR_W-1:0];
        end
      end
      dclc_pkg::DCLC_BUS_WAIT: begin
        next_r.bus = dclc_pkg::DCLC_BUS_RESP;
        next_r.rdata = 32'h0000_0000;
        if (!r.wr) begin
          if (r.addr == `DCLC_ADDR_STATUS) begin
            next_r.rdata[`DCLC_ST_AUX_LEVEL] = r.aux_sync[1];
            next_r.rdata[`DCLC_ST_HELD] = held;
            next_r.rdata[`DCLC_ST_GATED] = r.gated;
            next_r.rdata[`DCLC_ST_ACKED] = r.acked;
            next_r.rdata[`DCLC_ST_CAL_BUSY] = cal_busy;
            next_r.rdata[`DCLC_ST_CLEARING] = clearing;
          end else if (r.addr == `DCLC_ADDR_PENDING) begin
            next_r.rdata[11:0] = r.pending;
          end else if (r.addr == `DCLC_ADDR_LATCH) begin
            next_r.rdata[11:0] = r.latch;
          end else if (r.addr == `DCLC_ADDR_RETURN) begin
            next_r.rdata[11:0] = r.retval;
          end else if (r.addr == `DCLC_ADDR_CONFIG) begin
            next_r.rdata[`DCLC_CFG_AUX_LO+1:`DCLC_CFG_AUX_LO] = r.aux_mode;
            next_r.rdata[`DCLC_CFG_REF_LO+1:`DCLC_CFG_REF_LO] = r.ref_sel;
            next_r.rdata[`DCLC_CFG_PD_LO+1:`DCLC_CFG_PD_LO] = r.pd_mode;
            next_r.rdata[`DCLC_CFG_HOLD] = r.sw_hold;
          end
        end
      end
      dclc_pkg::DCLC_BUS_RESP: begin
        // a new address phase may overlap this response cycle
        if (addr_take) begin
          next_r.bus = dclc_pkg::DCLC_BUS_WAIT;
          next_r.wr = hwrite;
          next_r.addr = haddr[`DCLC_ADDR_W-1:0];
        end else begin
          next_r.bus = dclc_pkg::DCLC_BUS_IDLE;
        end
      end
      default: begin
        next_r.bus = dclc_pkg::DCLC_BUS_IDLE;
      end
    endcase
  end

  // power-on puts every code at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      // synchronisers start at the idle pin level, so no false clear or strobe follows reset
      r.aux_sync <= 2'b11;
      r.load_sync <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout = (r.bus != dclc_pkg::DCLC_BUS_WAIT);
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign dac_code = r.out_code[RES-1:0];
  assign ref_select = r.ref_sel;
  assign power_down_mode = r.pd_mode;

endmodule // dclc_core

// [tb/dclc_core_assertions.sv]
// port checker of the code latch control block
module dclc_checker #(
  parameter int RES = 12,
  parameter int CAL_CYCLES = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [RES-1:0] dac_code,
  input wire logic [1:0] ref_select,
  input wire logic [1:0] power_down_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // margin of four cycles keeps the window clear of the design's own boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 0;
    else if (cnt < CAL_CYCLES) cnt <= cnt + 1;
  end
  sequence taken_s; hsel && htrans[1] && hready; endsequence
  sequence answer_s; !hreadyout ##1 hreadyout; endsequence
  bus_wait_one_a: assert property (taken_s |=> answer_s)
    else $error("wait state not one cycle");
  bus_idle_ready_a: assert property (!(hsel && htrans[1]) && hreadyout |=> hreadyout)
    else $error("ready dropped without transfer");
  bus_resp_okay_a: assert property (hresp == 1'h0)
    else $error("error response");
  read_data_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data changed outside completion");
  reset_outputs_a: assert property ($rose(hresetn) |->
    dac_code == '0 && ref_select == 2'h0 && power_down_mode == 2'h0)
    else $error("outputs not at reset values");
  ref_by_bus_a: assert property ($changed(ref_select) |-> $rose(hreadyout))
    else $error("reference changed without a write");
  power_keeps_code_a: assert property ($changed(power_down_mode) |->
    $stable(dac_code) || power_down_mode == 2'h0)
    else $error("power mode change moved the code");
  cal_ignore_a: assert property (cnt < CAL_CYCLES - 4 |-> $stable(ref_select) &&
    $stable(power_down_mode) && $stable(dac_code))
    else $error("write acted during calibration");
endmodule // dclc_checker

// [tb/dclc_host.sv]
// bus master and pin driver standing in for the host
module dclc_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic aux_n,
  output logic load_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    aux_n = 1'h1;
    load_strobe_n = 1'h1;
  end
  // called just after a rising edge; waits as long as the slave stalls
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    logic rdy;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    // ready is read before the edge, since it moves with the slave's state at that edge
    do begin
      @(negedge hclk);
      rdy = (hready === 1'h1);
      @(posedge hclk);
    end while (!rdy);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge hclk);
      rdy = (hready === 1'h1);
      q = hrdata;
      @(posedge hclk);
    end while (!rdy);
  endtask
  // clear released before start, strobe pulsed or held low
  task automatic pins(input logic aux, input logic ld);
    aux_n <= aux;
    load_strobe_n <= ld;
  endtask
endmodule // dclc_host

// [tb/testbench.sv]
// self-checking bench of the code latch control block
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RES = 12;
  typedef struct packed {
    logic wr;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [11:0] ex;
    logic [11:0] dac;
  } dclc_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, aux_n, load_strobe_n;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, ref_select, power_down_mode;
  logic [2:0] hsize;
  logic [RES-1:0] dac_code;
  int num_errors, checks, cyc;
  dclc_row_t rows [17] = '{
    '{1'h1, 32'h0000_0123, 12'h00C, 12'h123, 12'h000},
    '{1'h1, 32'h6000_0001, 12'h018, 12'h010, 12'h000},
    '{1'h1, 32'h1000_0000, 12'h010, 12'h123, 12'h123},
    '{1'h1, 32'h2000_0ABC, 12'h010, 12'hABC, 12'hABC},
    '{1'h1, 32'h5000_0001, 12'h018, 12'h014, 12'hABC},
    '{1'h1, 32'h5000_0002, 12'h018, 12'h018, 12'hABC},
    '{1'h1, 32'h5000_0003, 12'h018, 12'h01C, 12'hABC},
    '{1'h1, 32'h5000_0000, 12'h018, 12'h010, 12'hABC},
    '{1'h1, 32'h3000_0055, 12'h014, 12'h055, 12'hABC},
    '{1'h1, 32'h9000_0001, 12'h010, 12'hABC, 12'h055},
    '{1'h1, 32'h0000_0321, 12'h00C, 12'h321, 12'h055},
    '{1'h1, 32'h9000_0000, 12'h010, 12'hABC, 12'hABC},
    '{1'h1, 32'h7000_0000, 12'h00C, 12'h055, 12'h055},
    '{1'h1, 32'h4000_0001, 12'h018, 12'h011, 12'h055},
    '{1'h1, 32'h4000_0002, 12'h018, 12'h012, 12'h055},
    '{1'h1, 32'h4000_0000, 12'h018, 12'h010, 12'h055},
    '{1'h0, 32'h0000_0000, 12'h0FC, 12'h000, 12'h055}};
  dclc_core #(.RES(RES), .CAL_CYCLES(16)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .aux_n(aux_n), .load_strobe_n(load_strobe_n), .dac_code(dac_code),
    .ref_select(ref_select), .power_down_mode(power_down_mode));
  dclc_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .aux_n(aux_n), .load_strobe_n(load_strobe_n));
  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'h0, a, 32'h0, q);
  endtask
  task automatic do_reset();
    hresetn <= 1'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
  endtask
  // three edges of pin synchronisation, one spare
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask
  initial begin
    hresetn = 1'h0;
    num_errors = 0;
    checks = 0;
    cyc = 0;
    do_reset();
    `CHK("dac", 12'h000, dac_code)
    wr(12'h000, 32'h5000_0002);
    `CHK("ref", 2'h0, ref_select)
    do rd(12'h008); while (q[4] !== 1'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(12'h000, rows[i].wd);
      rd(rows[i].ra);
      `CHK("row", rows[i].ex, q[11:0])
      `CHK("dac", rows[i].dac, dac_code)
    end
    u_host.pins(1'h0, 1'h1);
    settle();
    `CHK("dac", 12'h055, dac_code)
    wr(12'h000, 32'h2000_0333);
    rd(12'h008);
    `CHK("status", 4'h4, q[3:0])
    wr(12'h000, 32'h5000_0001);
    rd(12'h008);
    `CHK("status", 4'hC, q[3:0])
    `CHK("ref", 2'h1, ref_select)
    rd(12'h00C);
    `CHK("pending", 12'h055, q[11:0])
    u_host.pins(1'h1, 1'h1);
    settle();
    wr(12'h000, 32'h0000_0111);
    rd(12'h00C);
    `CHK("pending", 12'h055, q[11:0])
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h0000_0111);
    rd(12'h00C);
    `CHK("pending", 12'h111, q[11:0])
    u_host.pins(1'h1, 1'h0);
    wr(12'h000, 32'h0000_0222);
    settle();
    `CHK("dac", 12'h222, dac_code)
    u_host.pins(1'h0, 1'h0);
    settle();
    `CHK("dac", 12'h055, dac_code)
    u_host.pins(1'h1, 1'h1);
    settle();
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h8000_0000);
    rd(12'h018);
    `CHK("config", 12'h000, q[11:0])
    `CHK("dac", 12'h000, dac_code)
    wr(12'h000, 32'h2000_0456);
    do_reset();
    `CHK("dac", 12'h000, dac_code)
    finish_test();
  end
endmodule // testbench
bind dclc_core dclc_checker #(.RES(RES), .CAL_CYCLES(CAL_CYCLES)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dac_code(dac_code),
  .ref_select(ref_select), .power_down_mode(power_down_mode));
